/* src/scan_sequencer_trigger.sv */
// scan sequencer with arm, trigger and pre/post trigger scan counting
`timescale 1ns/100ps
// Notes on behaviour
// RL1: each scan entry keeps its own gain
// RL2: channel spacing one channel-clock period, 10/5 us
// RL3: scan list entries in any channel order
// RL4: each tick walks all entries, applying gain/range
// RL5: expansion card selects driven per entry
// RL6: armed state waits for trigger
// RL7: nonzero pre count: scan continuously until trigger
// RL8: zero pre count: idle until trigger
// RL9: post count scans then auto disarm
// RL10: trigger from software, TTL pin, analog level
// RL11: analog trigger reserves one output for threshold
// RL12: hold enable freezes all channels together
// RL13: channels stepped out while held
// RL14: up to 256 simultaneous channels
// RL15: host picks slow clock for slow cards
// RL16: four expansion address lines per entry
// RL17: host keeps scan period above list time
module scan_sequencer_trigger
(
   input wire logic I_CORE_CLK, // 100 MHz core clock
   input wire logic I_RSTN, // async reset, active low
   input wire logic [9:0] I_ADDR, // register word index
   input wire logic [31:0] I_WDATA, // write data
   input wire logic I_WR, // write strobe
   input wire logic I_RD, // read strobe
   output logic [31:0] O_RDATA, // read data, cycle after strobe
   input wire logic I_TTL_TRIG, // external trigger pin, async
   input wire logic I_ANALOG_CMP, // threshold comparator output, async
   output logic [scan_seq_pkg::BASE_W-1:0] O_BASE_SEL, // base channel mux select
   output logic [scan_seq_pkg::GAIN_W-1:0] O_GAIN, // base amplifier gain code
   output logic O_BIPOLAR, // range: 1 bipolar, 0 unipolar
   output logic [scan_seq_pkg::SUB_W-1:0] O_EXP_ADDR, // expansion connector sub-channel lines
   output logic [scan_seq_pkg::XGAIN_W-1:0] O_EXP_GAIN, // expansion connector gain lines
   output logic O_SAMPLE, // one-cycle convert request
   output logic O_SCAN_PRE, // sample belongs to a pre-trigger scan
   output logic O_HOLD, // simultaneous_sample_hold enable
   output logic O_THRESH_OWNED, // threshold output claimed by trigger
   output logic O_ARMED // acquisition armed
);
   import scan_seq_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed
   {
      acq_e st;
      logic [5:0] ctrl;
      logic [8:0] nentry;
      logic [31:0] period;
      logic [31:0] precnt;
      logic [31:0] postcnt;
      logic [31:0] tick_cnt; // scan timebase counter
      logic [31:0] scans; // scans taken in this phase
      logic walking; // scan in progress
      logic [7:0] idx; // current entry
      logic [9:0] chan_cnt; // channel clock counter
      logic [1:0] ttl_sync;
      logic [1:0] cmp_sync;
      logic ttl_prev;
      logic cmp_prev;
      logic sw_trig;
      logic [31:0] rdata;
      logic [BASE_W-1:0] base;
      logic [GAIN_W-1:0] gain;
      logic bip;
      logic [SUB_W-1:0] sub;
      logic [XGAIN_W-1:0] xgain;
      logic sample;
      logic pre_tag;
      logic hold;
   } state_s;

   state_s cur_ff;
   state_s nxt_ff;
   // scan list memory: independent gain, range and selects per entry
   logic [ENTRY_BITS-1:0] list_mem [LIST_DEPTH]; // [RL1] [RL3]
   logic [ENTRY_BITS-1:0] entry; // entry under the sequencer
   logic [ENTRY_BITS-1:0] rd_entry; // entry under a software read
   logic list_we; // list write
   logic [9:0] chan_period; // selected channel spacing
   logic trig_hit; // trigger event this cycle
   logic tick; // scan timebase tick
   logic entry_done; // channel period ended
   logic last_entry; // current entry is the last

   ////////////////////////////////////////////////////////////////////////
   // list memory, written directly by software
   assign list_we = I_WR && (I_ADDR[9:8] == A_LIST[9:8]);
   assign entry = list_mem[cur_ff.idx];
   assign rd_entry = list_mem[I_ADDR[7:0]];

   // memory holds no control state, so no reset is needed
   always_ff @(posedge I_CORE_CLK)
   begin
      if (list_we)
      begin
         list_mem[I_ADDR[7:0]] <= I_WDATA[ENTRY_BITS-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb
   begin
      nxt_ff = cur_ff;
      // pins pass two flops; only the second stage is compared
      nxt_ff.ttl_sync = {cur_ff.ttl_sync[0], I_TTL_TRIG};
      nxt_ff.cmp_sync = {cur_ff.cmp_sync[0], I_ANALOG_CMP};
      nxt_ff.ttl_prev = cur_ff.ttl_sync[1];
      nxt_ff.cmp_prev = cur_ff.cmp_sync[1];
      nxt_ff.sample = 1'b0;
      nxt_ff.sw_trig = 1'b0;
      // channel spacing from the clock select bit
      chan_period = cur_ff.ctrl[C_FAST] ? CHAN_CYC_FAST : CHAN_CYC_SLOW; // [RL2]
      // trigger source select
      case (cur_ff.ctrl[C_SRC_LSB +: 2]) // [RL10]
         SRC_TTL:
         begin
            trig_hit = cur_ff.ctrl[C_EDGE_FALL] ? (cur_ff.ttl_prev && !cur_ff.ttl_sync[1])
                                                : (!cur_ff.ttl_prev && cur_ff.ttl_sync[1]);
         end
         SRC_ANALOG:
         begin
            // comparator high means the input is above threshold
            trig_hit = cur_ff.ctrl[C_ABOVE] ? (!cur_ff.cmp_prev && cur_ff.cmp_sync[1])
                                            : (cur_ff.cmp_prev && !cur_ff.cmp_sync[1]);
         end
         default:
         begin
            trig_hit = cur_ff.sw_trig;
         end
      endcase
      // scan timebase counts only while scans may run
      tick = 1'b0;
      if (cur_ff.st == ST_PRE || cur_ff.st == ST_POST)
      begin
         if (cur_ff.tick_cnt == 32'h0)
         begin
            tick = 1'b1;
            nxt_ff.tick_cnt = cur_ff.period;
         end
         else
         begin
            nxt_ff.tick_cnt = cur_ff.tick_cnt - 32'h1;
         end
      end
      else
      begin
         nxt_ff.tick_cnt = 32'h0;
      end
      // entry walk: one sample per channel period
      entry_done = cur_ff.walking && (cur_ff.chan_cnt == 10'h0);
      last_entry = ({1'b0, cur_ff.idx} + 9'h1) >= cur_ff.nentry;
      if (tick && !cur_ff.walking && cur_ff.nentry != 9'h0)
      begin
         // a tick during a walk is lost; the host keeps the period long enough [RL17]
         nxt_ff.walking = 1'b1; // [RL4]
         nxt_ff.idx = 8'h0;
         nxt_ff.chan_cnt = 10'h0;
         nxt_ff.pre_tag = (cur_ff.st == ST_PRE);
         // freeze every hold stage for the whole scan in one edge
         nxt_ff.hold = cur_ff.ctrl[C_SIMUL]; // [RL12] [RL14]
      end
      else if (entry_done)
      begin
         // present entry selects and gain, then request the sample [RL4]
         nxt_ff.base = entry[F_BASE_LSB +: BASE_W];
         nxt_ff.gain = entry[F_GAIN_LSB +: GAIN_W]; // [RL1]
         nxt_ff.bip = entry[F_BIPOLAR];
         nxt_ff.sub = entry[F_SUB_LSB +: SUB_W]; // [RL5] [RL16]
         nxt_ff.xgain = entry[F_XGAIN_LSB +: XGAIN_W]; // [RL5]
         nxt_ff.sample = 1'b1; // [RL13]
         nxt_ff.chan_cnt = chan_period - 10'h1; // [RL2]
         if (last_entry)
         begin
            nxt_ff.walking = 1'b0;
            // a scan begun before the trigger does not count as a post scan
            if (cur_ff.pre_tag == (cur_ff.st == ST_PRE))
            begin
               nxt_ff.scans = cur_ff.scans + 32'h1;
            end
         end
         else
         begin
            nxt_ff.idx = cur_ff.idx + 8'h1;
         end
      end
      else if (cur_ff.walking)
      begin
         nxt_ff.chan_cnt = cur_ff.chan_cnt - 10'h1;
      end
      else
      begin
         // release the hold in the cycle after the last channel's convert request
         nxt_ff.hold = 1'b0;
      end
      // acquisition state machine
      case (cur_ff.st)
         ST_IDLE:
         begin
            nxt_ff.scans = 32'h0;
         end
         ST_PRE:
         begin
            // keep collecting until the trigger arrives [RL7]
            if (trig_hit)
            begin
               nxt_ff.st = ST_POST; // [RL6]
               nxt_ff.scans = 32'h0;
            end
         end
         ST_WAIT:
         begin
            // no scans while waiting [RL8]
            if (trig_hit)
            begin
               nxt_ff.st = (cur_ff.postcnt == 32'h0) ? ST_IDLE : ST_POST; // [RL6]
               nxt_ff.scans = 32'h0;
            end
         end
         ST_POST:
         begin
            // stop one cycle after the last post convert, so it goes out while armed [RL9]
            if (!cur_ff.walking && cur_ff.scans >= cur_ff.postcnt)
            begin
               nxt_ff.st = ST_IDLE;
               // a tick landing here must not start a walk after disarm
               nxt_ff.walking = 1'b0;
               nxt_ff.hold = 1'b0;
            end
         end
         default:
         begin
            nxt_ff.st = ST_IDLE;
         end
      endcase
      // register writes
      if (I_WR)
      begin
         case (I_ADDR)
            A_CTRL: nxt_ff.ctrl = I_WDATA[5:0];
            A_NENTRY: nxt_ff.nentry = (I_WDATA[8:0] > 9'(LIST_DEPTH)) ? 9'(LIST_DEPTH) : I_WDATA[8:0];
            A_PERIOD: nxt_ff.period = I_WDATA;
            A_PRECNT: nxt_ff.precnt = I_WDATA;
            A_POSTCNT: nxt_ff.postcnt = I_WDATA;
            A_COMMAND:
            begin
               if (I_WDATA[K_DISARM])
               begin
                  nxt_ff.st = ST_IDLE;
                  nxt_ff.walking = 1'b0;
                  nxt_ff.hold = 1'b0;
                  nxt_ff.sample = 1'b0;
               end
               else if (I_WDATA[K_ARM] && cur_ff.st == ST_IDLE)
               begin
                  nxt_ff.st = (cur_ff.precnt != 32'h0) ? ST_PRE : ST_WAIT; // [RL7] [RL8]
                  nxt_ff.scans = 32'h0;
               end
               nxt_ff.sw_trig = I_WDATA[K_SWTRIG] && cur_ff.st != ST_IDLE; // [RL10]
            end
            default:
            begin
            end
         endcase
      end
      // reads: data stand in the cycle after the strobe, zero otherwise
      nxt_ff.rdata = 32'h0;
      if (I_RD)
      begin
         case (I_ADDR)
            A_CTRL: nxt_ff.rdata = {26'h0, cur_ff.ctrl};
            A_STATUS: nxt_ff.rdata = {26'h0, cur_ff.walking, cur_ff.hold, cur_ff.st};
            A_NENTRY: nxt_ff.rdata = {23'h0, cur_ff.nentry};
            A_PERIOD: nxt_ff.rdata = cur_ff.period;
            A_PRECNT: nxt_ff.rdata = cur_ff.precnt;
            A_POSTCNT: nxt_ff.rdata = cur_ff.postcnt;
            A_SCANCNT: nxt_ff.rdata = cur_ff.scans;
            default:
            begin
               if (I_ADDR[9:8] == A_LIST[9:8])
               begin
                  nxt_ff.rdata = {19'h0, rd_entry};
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge I_CORE_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         cur_ff <= '{st: ST_IDLE, default: '0};
      end
      else
      begin
         cur_ff <= nxt_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   // read data come straight from a flop and stand for one cycle
   assign O_RDATA = cur_ff.rdata;
   assign O_BASE_SEL = cur_ff.base;
   assign O_GAIN = cur_ff.gain;
   assign O_BIPOLAR = cur_ff.bip;
   assign O_EXP_ADDR = cur_ff.sub; // [RL16]
   assign O_EXP_GAIN = cur_ff.xgain;
   assign O_SAMPLE = cur_ff.sample;
   assign O_SCAN_PRE = cur_ff.pre_tag;
   assign O_HOLD = cur_ff.hold;
   // threshold output is reserved whenever analog triggering is selected
   assign O_THRESH_OWNED = (cur_ff.ctrl[C_SRC_LSB +: 2] == SRC_ANALOG); // [RL11]
   assign O_ARMED = (cur_ff.st != ST_IDLE); // [RL6]
endmodule

/* src/scan_seq_pkg.sv */
// constants, types and timing for the scan sequencer and trigger control
package scan_seq_pkg;
   // channel clock periods in ns and derived cycle counts at the 100 MHz core clock
   localparam int CORE_PERIOD_NS = 10;
   localparam int CHAN_PERIOD_SLOW_NS = 10000;
   localparam int CHAN_PERIOD_FAST_NS = 5000;
   localparam logic [9:0] CHAN_CYC_SLOW = 10'((CHAN_PERIOD_SLOW_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS);
   localparam logic [9:0] CHAN_CYC_FAST = 10'((CHAN_PERIOD_FAST_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS);
   // hold skew bound: all hold stages share one enable, well inside this figure
   localparam int HOLD_SKEW_NS = 50;
   // scan list geometry
   localparam int ENTRY_W = 8;
   localparam int LIST_DEPTH = 256;
   localparam int BASE_W = 4;
   localparam int SUB_W = 4;
   localparam int GAIN_W = 2;
   localparam int XGAIN_W = 2;
   localparam int ENTRY_BITS = 13;
   // entry field positions
   localparam int F_BASE_LSB = 0;
   localparam int F_SUB_LSB = 4;
   localparam int F_GAIN_LSB = 8;
   localparam int F_XGAIN_LSB = 10;
   localparam int F_BIPOLAR = 12;
   // register offsets (word indices)
   localparam logic [9:0] A_CTRL = 10'h000;
   localparam logic [9:0] A_STATUS = 10'h001;
   localparam logic [9:0] A_NENTRY = 10'h002;
   localparam logic [9:0] A_PERIOD = 10'h003;
   localparam logic [9:0] A_PRECNT = 10'h004;
   localparam logic [9:0] A_POSTCNT = 10'h005;
   localparam logic [9:0] A_COMMAND = 10'h006;
   localparam logic [9:0] A_SCANCNT = 10'h007;
   localparam logic [9:0] A_LIST = 10'h100;
   // control field positions
   localparam int C_FAST = 0;
   localparam int C_SRC_LSB = 1;
   localparam int C_SIMUL = 3;
   localparam int C_EDGE_FALL = 4;
   localparam int C_ABOVE = 5;
   // command bits
   localparam int K_ARM = 0;
   localparam int K_SWTRIG = 1;
   localparam int K_DISARM = 2;
   // trigger sources
   localparam logic [1:0] SRC_SW = 2'h0;
   localparam logic [1:0] SRC_TTL = 2'h1;
   localparam logic [1:0] SRC_ANALOG = 2'h2;
   // acquisition states, one-hot
   typedef enum logic [3:0]
   {
      ST_IDLE = 4'h1,
      ST_PRE = 4'h2,
      ST_WAIT = 4'h4,
      ST_POST = 4'h8
   } acq_e;
endpackage

/* test/scan_seq_checker.sv */
// port assertions for the scan sequencer
`timescale 1ns/100ps
module scan_seq_checker
import scan_seq_pkg::*;
(
   input wire logic I_CORE_CLK, // core clock
   input wire logic I_RSTN, // reset, active low
   input wire logic [9:0] I_ADDR, // word index
   input wire logic [31:0] I_WDATA, // write data
   input wire logic I_WR, // write strobe
   input wire logic O_SAMPLE, // convert request
   input wire logic [BASE_W-1:0] O_BASE_SEL, // base select
   input wire logic [SUB_W-1:0] O_EXP_ADDR, // sub-channel lines
   input wire logic O_SCAN_PRE, // pre-trigger scan
   input wire logic O_HOLD, // hold enable
   input wire logic O_THRESH_OWNED, // threshold claimed
   input wire logic O_ARMED // armed
);
////////////////////////////////////////////////////////////
default clocking cb @(posedge I_CORE_CLK); endclocking
default disable iff (!I_RSTN);
logic [31:0] ctrl_ff; // shadow of the control word
logic pz_ff; // pre count is zero
logic [11:0] gap_ff; // cycles since last convert, saturating
logic [9:0] sp; // channel spacing in cycles
assign sp = ctrl_ff[C_FAST] ? CHAN_CYC_FAST : CHAN_CYC_SLOW;
// shadows follow host writes; gap saturates so long idles never wrap
always_ff @(posedge I_CORE_CLK or negedge I_RSTN)
begin
   if (!I_RSTN)
   begin
      ctrl_ff <= 32'h0;
      pz_ff <= 1'b1;
      gap_ff <= 12'h0;
   end
   else
   begin
      if (I_WR && I_ADDR == A_CTRL)
         ctrl_ff <= I_WDATA;
      if (I_WR && I_ADDR == A_PRECNT)
         pz_ff <= (I_WDATA == 32'h0);
      if (O_SAMPLE)
         gap_ff <= 12'h1;
      else if (gap_ff != 12'h0 && gap_ff != 12'hFFF)
         gap_ff <= gap_ff + 12'h1;
   end
end
////////////////////////////////////////////////////////////
chk_one_pulse: assert property (O_SAMPLE |=> !O_SAMPLE)
   else $error("convert request wider than one cycle");
chk_chan_gap: assert property (O_SAMPLE && gap_ff != 12'h0 |-> gap_ff >= {2'h0, sp})
   else $error("converts closer than one channel period");
chk_sel_change: assert property ($changed(O_BASE_SEL) || $changed(O_EXP_ADDR) |-> O_SAMPLE)
   else $error("selects moved outside a convert");
chk_thresh_own: assert property ($stable(ctrl_ff) |-> O_THRESH_OWNED == (ctrl_ff[C_SRC_LSB+:2] == SRC_ANALOG))
   else $error("threshold claim does not follow source");
chk_hold_simul: assert property (O_SAMPLE |-> O_HOLD == ctrl_ff[C_SIMUL])
   else $error("hold enable wrong during convert");
chk_idle_quiet: assert property (!O_ARMED |-> !O_SAMPLE)
   else $error("convert while disarmed");
chk_arm_taken: assert property (I_WR && I_ADDR == A_COMMAND && I_WDATA[K_ARM] && !I_WDATA[K_DISARM] && !O_ARMED
   |-> ##[1:2] O_ARMED)
   else $error("arm command not taken");
chk_pre_zero: assert property (O_SAMPLE && pz_ff |-> !O_SCAN_PRE)
   else $error("pre-trigger scan with zero pre count");
cover property (O_SAMPLE && O_HOLD);
cover property (O_SAMPLE && O_SCAN_PRE);
cover property (O_THRESH_OWNED && O_ARMED);
endmodule
bind scan_sequencer_trigger scan_seq_checker scan_seq_checker_inst (.I_CORE_CLK(I_CORE_CLK), .I_RSTN(I_RSTN),
   .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .O_SAMPLE(O_SAMPLE), .O_BASE_SEL(O_BASE_SEL),
   .O_EXP_ADDR(O_EXP_ADDR), .O_SCAN_PRE(O_SCAN_PRE), .O_HOLD(O_HOLD), .O_THRESH_OWNED(O_THRESH_OWNED),
   .O_ARMED(O_ARMED));

/* test/scan_card_model.sv */
// expansion card model: takes the selects presented with each convert request
`timescale 1ns/100ps
module scan_card_model
(
   input wire logic clk, // core clock
   input wire logic rst_n, // reset, active low
   input wire logic i_sample, // convert request
   input wire logic [14:0] i_sel, // hold, pre flag and entry selects
   output logic o_got, // one cycle: a word was taken
   output logic [14:0] o_word // selects seen at the convert
);
////////////////////////////////////////////////////////////
// mux and amp only matter at the convert moment, so nothing else is kept
always_ff @(posedge clk or negedge rst_n)
begin
   if (!rst_n)
   begin
      o_got <= 1'b0;
      o_word <= 15'h0;
   end
   else
   begin
      o_got <= i_sample;
      if (i_sample)
         o_word <= i_sel;
   end
end
endmodule

/* test/tb_top.sv */
// self-checking bench for the scan sequencer
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; $display("ERROR %0t: %h want %h", $time, a, b); end end
module tb_top;
import scan_seq_pkg::*;
logic clk;
logic rst_n;
logic [9:0] addr;
logic [31:0] wdata;
logic wr, rd, ttl, acmp;
logic [31:0] rdata;
logic [3:0] base_sel, exp_addr;
logic [1:0] gain, exp_gain;
logic bip, sample, pre, hold, owned, armed, got;
logic [14:0] word; // card's view of a convert
logic [31:0] rq[$]; // expected read data
logic [14:0] sq[$]; // expected card words
logic [12:0] ent[4]; // image of the scan list
logic rd_p; // read strobe, one cycle late
logic [7:0] lf;
logic [31:0] exp_r; // oldest expected read word
logic [14:0] exp_w; // oldest expected card word
int err_total, cmp_count, cyc, sp;
int last = -100000; // cycle of the previous convert
////////////////////////////////////////////////////////////
function automatic logic [7:0] lfsr(input logic [7:0] v);
   return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
endfunction
initial
begin
   clk = 1'b0;
   forever #5 clk = ~clk;
end
scan_sequencer_trigger scan_sequencer_trigger_inst (.I_CORE_CLK(clk), .I_RSTN(rst_n), .I_ADDR(addr),
   .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_TTL_TRIG(ttl), .I_ANALOG_CMP(acmp),
   .O_BASE_SEL(base_sel), .O_GAIN(gain), .O_BIPOLAR(bip), .O_EXP_ADDR(exp_addr), .O_EXP_GAIN(exp_gain),
   .O_SAMPLE(sample), .O_SCAN_PRE(pre), .O_HOLD(hold), .O_THRESH_OWNED(owned), .O_ARMED(armed));
scan_card_model scan_card_model_inst (.clk(clk), .rst_n(rst_n), .i_sample(sample),
   .i_sel({hold, pre, bip, exp_gain, gain, exp_addr, base_sel}), .o_got(got), .o_word(word));
////////////////////////////////////////////////////////////
// read pipeline and hang guard
always @(posedge clk)
begin
   rd_p <= rd;
   cyc <= cyc + 1;
   if (cyc == 40000)
   begin
      err_total++;
      end_of_test();
   end
end
// watcher: read data and card words against the oldest notes
always @(negedge clk)
begin
   if (rd_p)
   begin
      exp_r = rq.pop_front();
      `CHK(rdata, exp_r)
   end
   if (got)
   begin
      if (sq.size() == 0)
      begin
         err_total++;
         $display("ERROR %0t: convert not expected", $time);
      end
      else
      begin
         exp_w = sq.pop_front();
         `CHK(word, exp_w)
      end
      if (cyc - last < sp + sp / 2)
         `CHK(cyc - last, sp)
      last = cyc;
   end
end
////////////////////////////////////////////////////////////
task automatic bus_wr(input logic [9:0] a, input logic [31:0] d);
   @(posedge clk);
   addr <= a;
   wdata <= d;
   wr <= 1'b1;
   @(posedge clk);
   wr <= 1'b0;
endtask
task automatic bus_rd(input logic [9:0] a, input logic [31:0] e);
   rq.push_back(e);
   @(posedge clk);
   addr <= a;
   rd <= 1'b1;
   @(posedge clk);
   rd <= 1'b0;
endtask
// one acquisition: random list, arm, pre scans, trigger, post scans
task automatic acq(input logic [31:0] ctrl, input logic [31:0] npre, input logic [31:0] npost, input int n);
   int i;
   sp = ctrl[C_FAST] ? 500 : 1000;
   for (i = 0; i < n; i++)
   begin
      lf = lfsr(lf);
      ent[i][12:8] = lf[4:0];
      lf = lfsr(lf);
      ent[i][7:0] = lf;
      bus_wr(A_LIST + 10'(i), {19'h0, ent[i]});
   end
   bus_wr(A_NENTRY, 32'(n));
   // park the trigger pins on the level ahead of the chosen edge
   ttl <= ctrl[C_EDGE_FALL];
   acmp <= !ctrl[C_ABOVE];
   bus_wr(A_PERIOD, 32'h0FA0); // 4000 cycles outlasts a list of three
   bus_wr(A_PRECNT, npre);
   bus_wr(A_POSTCNT, npost);
   bus_wr(A_CTRL, ctrl); // slow clock whenever the list is slow
   @(negedge clk);
   `CHK(owned, ctrl[2:1] == SRC_ANALOG)
   for (i = 0; i < n && npre != 0; i++)
      sq.push_back({ctrl[C_SIMUL], 1'b1, ent[i]});
   bus_wr(A_COMMAND, 32'h1);
   for (i = 0; i < 8000 && sq.size() != 0; i++)
      @(posedge clk);
   repeat (1500) @(posedge clk);
   if (npre == 0)
      bus_rd(A_STATUS, 32'h4); // armed and waiting with no scans
   for (i = 0; i < npost * n; i++)
      sq.push_back({ctrl[C_SIMUL], 1'b0, ent[i % n]});
   case (ctrl[2:1])
      SRC_SW: bus_wr(A_COMMAND, 32'h2);
      SRC_TTL: ttl <= !ctrl[C_EDGE_FALL];
      default: acmp <= ctrl[C_ABOVE];
   endcase
   for (i = 0; i < 20000 && armed !== 1'b0; i++)
      @(posedge clk);
   `CHK(armed, 1'b0)
   `CHK(sq.size(), 0)
   ttl <= 1'b0;
   acmp <= 1'b0;
endtask
task automatic end_of_test();
   $display("TB: errors %0d, compares %0d", err_total, cmp_count);
   if (err_total == 0 && cmp_count > 0)
      $display("TB: PASS");
   else
      $display("TB: FAIL");
   $finish;
endtask
////////////////////////////////////////////////////////////
// main sequence: registers, then five acquisitions across the three trigger sources
initial
begin
   {rst_n, wr, rd, ttl, acmp, addr, wdata} = '0;
   lf = 8'h58;
   repeat (5) @(posedge clk);
   rst_n <= 1'b1;
   bus_rd(A_STATUS, 32'h1);
   bus_rd(A_CTRL, 32'h0);
   bus_wr(10'h0FF, 32'hFFFF_FFFF); // unmapped place
   bus_rd(10'h0FF, 32'h0);
   bus_wr(A_STATUS, 32'h0000_000F); // read-only place
   bus_rd(A_STATUS, 32'h1);
   acq(32'h0000_0000, 32'h1, 32'h2, 3);
   acq(32'h0000_000B, 32'h0, 32'h1, 2);
   acq(32'h0000_0024, 32'h0, 32'h1, 1);
   acq(32'h0000_0012, 32'h0, 32'h1, 1); // falling pin edge
   acq(32'h0000_0004, 32'h0, 32'h1, 1); // falling analog crossing
   end_of_test();
end
endmodule
